/* File: zt_xor_pkg.sv */
package zt_xor_pkg;
   localparam int DATA_W = 8;
   localparam int INSN_W = 16;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   // Opcode templates and masks
   localparam logic [15:0] TSTZ_MASK = 16'hFE00;
   localparam logic [15:0] TSTZ_CODE = 16'h6600;
   localparam logic [15:0] XORK_MASK = 16'hFF00;
   localparam logic [15:0] XORK_CODE = 16'h0A00;
   localparam int ACC_SEL_BIT = 8;
   // Access bank split: low part maps to bank 0 (to indexBase + offset when extendedSet), rest to top bank
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [3:0] TOP_BANK = 4'hF;
   localparam logic [3:0] LOW_BANK = 4'h0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   typedef enum logic [1:0] {EXEC, SKIP1, SKIP2} phase_t;
endpackage : zt_xor_pkg

/* File: operand_ram.sv */
`timescale 1ns/1ps
module operand_ram #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   // Registered read; no reset so it maps to block memory
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : operand_ram

/* File: zero_test_skip_and_xor_literal.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module zero_test_skip_and_xor_literal
   import zt_xor_pkg::*;
#(
   parameter int AW = zt_xor_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic insnValid,
   input wire logic [zt_xor_pkg::INSN_W-1:0] insnWord,
   input wire logic nextIsTwoWord,
   input wire logic extendedSet,
   input wire logic [zt_xor_pkg::BANK_W-1:0] bankPageSelector,
   input wire logic [AW-1:0] indexBase,
   input wire logic memWrEn,
   input wire logic [AW-1:0] memWrAddr,
   input wire logic [zt_xor_pkg::DATA_W-1:0] memWrData,
   output logic [zt_xor_pkg::DATA_W-1:0] accumulator,
   output logic negFlag,
   output logic zeroFlag,
   output logic discardFetch,
   output logic busy,
   output logic skipTaken
);
   import zt_xor_pkg::*;

   typedef struct packed {
      phase_t phase;
      logic testPend;
      logic pendTwoWord;
      logic [DATA_W-1:0] acc;
      logic neg;
      logic zero;
      logic discard;
      logic busy;
      logic skip;
   } state_t;

   state_t st_r, st_nxt;
   logic [AW-1:0] rdAddr;
   logic [DATA_W-1:0] rdData;
   logic isTest, isXor, accSel;
   logic [DATA_W-1:0] fAddr, xorRes;

   //////////////////////////////////////////////////////////////////////////
   assign isTest = insnValid && ((insnWord & TSTZ_MASK) == TSTZ_CODE);
   assign isXor = insnValid && ((insnWord & XORK_MASK) == XORK_CODE);
   assign fAddr = insnWord[DATA_W-1:0];
   assign accSel = insnWord[ACC_SEL_BIT];

   // Operand address formation
   always_comb begin
      if (accSel) begin
         rdAddr = AW'({bankPageSelector, fAddr});
      end else if (extendedSet && fAddr <= INDEX_LIMIT) begin
         rdAddr = AW'(indexBase + AW'(fAddr));
      end else if (fAddr < ACCESS_SPLIT) begin
         rdAddr = AW'({LOW_BANK, fAddr});
      end else begin
         rdAddr = AW'({TOP_BANK, fAddr});
      end
   end

   operand_ram #(.AW(AW), .DW(DATA_W)) u_ram (
      .clk(clk),
      .wrEn(memWrEn),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdAddr(rdAddr),
      .rdData(rdData)
   );

   assign xorRes = st_r.acc ^ insnWord[DATA_W-1:0];

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      st_nxt.discard = 1'b0;
      st_nxt.skip = 1'b0;
      st_nxt.testPend = 1'b0;
      unique case (st_r.phase)
         EXEC: begin
            // Operand arrives one cycle later from the registered memory
            if (st_r.testPend && rdData == ZERO_BYTE) begin
               st_nxt.discard = 1'b1;
               st_nxt.skip = 1'b1;
               st_nxt.busy = 1'b1;
               st_nxt.phase = st_r.pendTwoWord ? SKIP2 : SKIP1;
            end else begin
               st_nxt.busy = 1'b0;
               if (isTest) begin
                  st_nxt.testPend = 1'b1;
                  st_nxt.pendTwoWord = nextIsTwoWord;
               end else if (isXor) begin
                  st_nxt.acc = xorRes;
                  st_nxt.neg = xorRes[DATA_W-1];
                  st_nxt.zero = (xorRes == ZERO_BYTE);
               end
            end
         end
         SKIP2: begin
            // Second no-op for the trailing word; flags left alone
            st_nxt.discard = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.phase = SKIP1;
         end
         SKIP1: begin
            st_nxt.busy = 1'b0;
            st_nxt.phase = EXEC;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '{phase: EXEC, testPend: 1'b0, pendTwoWord: 1'b0,
                   acc: ACC_RESET, neg: 1'b0, zero: 1'b0, discard: 1'b0,
                   busy: 1'b0, skip: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign accumulator = st_r.acc;
   assign negFlag = st_r.neg;
   assign zeroFlag = st_r.zero;
   assign discardFetch = st_r.discard;
   assign busy = st_r.busy;
   assign skipTaken = st_r.skip;
endmodule : zero_test_skip_and_xor_literal

/* File: zt_xor_chk.sv */
`timescale 1ns/1ps
module zt_chk import zt_xor_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic insnValid,
   input wire logic [15:0] insnWord,
   input wire logic nextIsTwoWord,
   input wire logic busy,
   input wire logic discardFetch,
   input wire logic skipTaken,
   input wire logic [7:0] accumulator,
   input wire logic negFlag,
   input wire logic zeroFlag
);
   wire logic tk = insnValid && !busy && (insnWord & TSTZ_MASK) == TSTZ_CODE;
   wire logic tx = insnValid && !busy && (insnWord & XORK_MASK) == XORK_CODE;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence dbl; discardFetch && busy ##1 !busy; endsequence
   chk_skip_cause: assert property (skipTaken |-> $past(tk, 2))
      else $error("skip without zero test");
   chk_skip_pulse: assert property (
      skipTaken |-> discardFetch && busy ##1 !skipTaken) else $error("pulse");
   chk_two_word: assert property (
      skipTaken && $past(nextIsTwoWord, 2) |=> dbl) else $error("two-word");
   chk_one_word: assert property (
      skipTaken && !$past(nextIsTwoWord, 2) |=> !busy) else $error("one-word");
   chk_discard_busy: assert property (discardFetch |-> busy)
      else $error("discard outside skip");
   // Xor right after a test may be the skipped word, so leave it out
   chk_xor_result: assert property (tx && !$past(tk) |=>
      accumulator == ($past(accumulator) ^ $past(insnWord[7:0]))
      && negFlag == accumulator[7] && zeroFlag == (accumulator == 8'h00))
      else $error("xor result or flags wrong");
   chk_flags_hold: assert property (discardFetch |->
      $stable(negFlag) && $stable(zeroFlag) && $stable(accumulator))
      else $error("skip changed flags");
endmodule : zt_chk
bind zero_test_skip_and_xor_literal zt_chk chk (.*);

/* File: zero_test_skip_and_xor_literal_test.sv */
`timescale 1ns/1ps
module zero_test_skip_and_xor_literal_test;
   import zt_xor_pkg::*;
   typedef struct {logic e; logic [8:0] f; logic [11:0] ad; logic w;} row_t;
   row_t rows [6] = '{'{1'h0, 9'h125, 12'h325, 1'h0},
      '{1'h0, 9'h1FF, 12'h3FF, 1'h1}, '{1'h0, 9'h025, 12'h025, 1'h1},
      '{1'h0, 9'h0A0, 12'hFA0, 1'h0}, '{1'h1, 9'h05F, 12'h25F, 1'h1},
      '{1'h1, 9'h060, 12'hF60, 1'h0}};
   logic clk = 1'h0, rst = 1'h1, insnValid = 1'h0, nextIsTwoWord = 1'h0;
   logic extendedSet = 1'h0, memWrEn = 1'h0, nf = 1'h0, zf = 1'h0;
   logic negFlag, zeroFlag, busy, discardFetch, skipTaken;
   logic [15:0] insnWord = 16'h0000;
   // Bank and index base fixed; row addresses are built on them
   logic [3:0] bankPageSelector = 4'h3;
   logic [11:0] indexBase = 12'h200, memWrAddr = 12'h000;
   logic [7:0] memWrData = 8'h00, accumulator, acc = 8'h00, ns, nd;
   int bad_count = 0, compares = 0;
   always #10 clk = ~clk;
   zero_test_skip_and_xor_literal dut (.*);
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] g, w);
      compares++;
      bad_count += int'(g !== w);
      if (g !== w) $display("Error %0t: got %h want %h", $time, g, w);
   endtask : chk
   task finish_test;
      $display("bad_count %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task tst(input row_t r, input logic [7:0] d);
      @(negedge clk);
      {memWrEn, memWrAddr, memWrData} = {1'h1, r.ad, d};
      @(negedge clk);
      {memWrEn, insnValid, extendedSet, nextIsTwoWord} = {2'h1, r.e, r.w};
      insnWord = {7'h33, r.f};
      @(negedge clk);
      // Follow-up xor only lands when the operand is nonzero
      insnWord = {8'h0A, r.ad[7:0]};
      @(negedge clk);
      {insnValid, ns, nd} = 17'h00000;
      if (d) {nf, zf} = {acc[7] ^ r.ad[7], acc == r.ad[7:0]};
      if (d) acc ^= r.ad[7:0];
      repeat (4) begin
         ns += skipTaken;
         nd += discardFetch;
         @(negedge clk);
      end
      chk(ns, {7'h00, !d});
      chk(nd, d ? 8'h00 : {6'h00, r.w, !r.w});
      chk(accumulator, acc);
      chk({6'h00, negFlag, zeroFlag}, {6'h00, nf, zf});
   endtask : tst
   initial begin
      repeat (16) @(negedge clk);
      chk({3'h0, negFlag, zeroFlag, busy, discardFetch, skipTaken}, 8'h00);
      chk(accumulator, ACC_RESET);
      rst = 1'h0;
      foreach (rows[i]) begin
         tst(rows[i], 8'h00);
         tst(rows[i], 8'h01);
      end
      finish_test;
   end
endmodule : zero_test_skip_and_xor_literal_test
